// [rtl/bcw_top.sv]
/*
 boot configuration word decoder top: applies the nonvolatile boot word at
 power-on and at each warm reset, and exposes it over an apb slave.
 assumes flash_cfg_word is the stable flash content and sys_warm_reset is a
 one-cycle pulse synchronous to pclk.
*/
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
// Contract
// RULE_01 - clock code 000 crystal, 111 rc, others reserved
// RULE_02 - every reset copies clock code into select
// RULE_03 - bit 23 low enables brown-out detect
// RULE_04 - bit 20 low enables brown-out reset
// RULE_05 - brown-out level field drives threshold select
// RULE_06 - bit 10 picks tri-state or quasi gpio
// RULE_07 - mode 11 boots and executes application only
// RULE_08 - mode 11 blocks application flash writes
// RULE_09 - mode 01 boots and executes loader only
// RULE_10 - mode 01 blocks loader flash writes
// RULE_11 - mode 10 boots application, executes both
// RULE_12 - both-region modes allow low page remap
// RULE_13 - mode 00 boots loader, low page from loader
// RULE_14 - changed word applies only at next reboot
`timescale 1ns/100ps
`include "bcw_defines.svh"
module bcw_top #(
   parameter int NUM_GPIO = 16,   // gpio pins steered by the initial mode
   parameter int PAGE_W   = 8,    // width of the remap page index
   parameter int MAX_PAGE = 255   // last page inside the executable range
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // boot word and warm reset request
   input  wire logic [31:0]         flash_cfg_word,
   input  wire logic                sys_warm_reset,
   // decoded start-up state, from flops except the reserved clock flag, which is decoded from the applied word
   output logic      [2:0]          clock_select_register_zero,
   output logic                     clk_src_reserved,
   output logic                     brownout_detect_en,
   output logic                     brownout_reset_en,
   output logic      [1:0]          brownout_level,
   output logic      [NUM_GPIO-1:0] gpio_quasi_mode,
   output bcw_pkg::bcw_boot_t       boot_ctl,
   output logic      [PAGE_W-1:0]   remap_page,
   output logic                     cfg_loaded
);
   import bcw_pkg::*;

   // parameter checks
   // the remap range must be reachable by the page index
   initial
   begin
      if (NUM_GPIO < 1 || PAGE_W < 1 || PAGE_W > 24)
         $error("bcw_top: bad width parameter");
      if (MAX_PAGE < 0 || MAX_PAGE >= (1 << PAGE_W))
         $error("bcw_top: MAX_PAGE does not fit PAGE_W");
   end

   // sequencer
   bcw_state_t        state_q;        // load sequencer
   bcw_state_t        state_d;        // its next value

   // applied word and its fields
   logic [31:0]       active_q;       // word applied at the last reboot
   logic              por_pend_q;     // power-on-only fields still to load
   logic [2:0]        clksel_q;       // core clock select field
   logic              bod_en_q;       // brown-out detect enable
   logic              bor_en_q;       // brown-out reset enable
   logic [1:0]        bov_q;          // brown-out threshold select
   logic              gpio_q;         // quasi-bidirectional start-up
   logic [PAGE_W-1:0] remap_q;        // low page remap target
   logic              loaded_q;       // first apply done

   // software side
   logic              reboot_req_q;   // software-requested reboot

   // combinational decode
   logic              rsv_clk;        // applied clock code is reserved
   logic              load;           // apply strobe this cycle
   logic              wr_en;          // apb write access phase
   logic              rd_en;          // apb read access phase
   logic              addr_ok;        // address maps a register
   logic              remap_refuse;   // remap write outside allowed mode or past MAX_PAGE
   logic [31:0]       rdata_d;        // read mux

   bcw_cfg_if cfg_if ();   // carrier to the boot decoder

   // byte-address match, used by every register decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // clock code check, shared by the status view and the flag output
   function automatic logic clk_code_rsv(input logic [2:0] c);
      return c != `BCW_CLK_XTAL && c != `BCW_CLK_IRC;   // [RULE_01]
   endfunction

   // zero-wait slave: every access finishes in its first access cycle
   // (all registers are flops, the decode is shallow)
   assign pready = 1'b1;
   assign wr_en  = psel && penable && pwrite;
   assign rd_en  = psel && penable && !pwrite;
   assign addr_ok = hit(paddr, `BCW_OFS_ACTIVE) || hit(paddr, `BCW_OFS_CLKSEL)
                 || hit(paddr, `BCW_OFS_REMAP) || hit(paddr, `BCW_OFS_STATUS)
                 || hit(paddr, `BCW_OFS_CTRL);
   // remap only in modes that execute from both regions
   // the range test reads the bus value, so a bad page never lands
   assign remap_refuse = hit(paddr, `BCW_OFS_REMAP)
                      && (!boot_ctl.remap_ok || pwdata[PAGE_W-1:0] > MAX_PAGE[PAGE_W-1:0]);
   // error on unmapped address or on a refused remap write
   assign pslverr = psel && penable && (!addr_ok || (pwrite && remap_refuse));

   // the load strobe is the sequencer state itself
   assign load    = state_q == BCW_ST_LOAD;
   // reserved flag follows the applied word, not the bus view
   assign rsv_clk = clk_code_rsv(active_q[`BCW_CLKSRC_MSB:`BCW_CLKSRC_LSB]);

   // sequencer: a reset or reboot request always passes through one load cycle
   // reset leaves it in load, so the first edge after release
   // samples the word
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         BCW_ST_LOAD : state_d = BCW_ST_RUN;
         BCW_ST_RUN  :
            if (sys_warm_reset || reboot_req_q)
               state_d = BCW_ST_LOAD;
         default     : state_d = BCW_ST_LOAD;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= BCW_ST_LOAD;
      else
         state_q <= state_d;
   end

   // applied word: sampled only while loading, so later flash edits wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active_q <= `BCW_RST_WORD;
      else if (load)
         active_q <= flash_cfg_word;   // [RULE_14]
   end

   // the first load after power-on also sets the power-on-only fields
   // a warm reboot finds it clear and skips them
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         por_pend_q <= 1'b1;
      else if (load)
         por_pend_q <= 1'b0;
   end

   // first-apply flag
   // only power-on reset clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         loaded_q <= 1'b0;
      else if (load)
         loaded_q <= 1'b1;
   end

   // clock select: reloaded at every reset kind, software may change it later;
   // the load wins over a write in the same cycle
   // a reserved code written here is taken as is
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clksel_q <= `BCW_RST_CLKSEL;
      else if (load)
         clksel_q <= flash_cfg_word[`BCW_CLKSRC_MSB:`BCW_CLKSRC_LSB];   // [RULE_02]
      else if (wr_en && hit(paddr, `BCW_OFS_CLKSEL))
         clksel_q <= pwdata[2:0];
   end

   // brown-out and gpio start-up state: power-on only, a warm reset keeps them
   // limitation: a new threshold needs a full power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bod_en_q <= 1'b0;
         bor_en_q <= 1'b0;
         bov_q    <= 2'h0;
         gpio_q   <= 1'b0;
      end
      else if (load && por_pend_q)
      begin
         bod_en_q <= !flash_cfg_word[`BCW_BOD_DIS_BIT];                 // [RULE_03]
         bor_en_q <= !flash_cfg_word[`BCW_BOR_DIS_BIT];                 // [RULE_04]
         bov_q    <= flash_cfg_word[`BCW_BOV_MSB:`BCW_BOV_LSB];         // [RULE_05]
         gpio_q   <= flash_cfg_word[`BCW_GPIO_BIT];                     // [RULE_06]
      end
   end

   // remap target: cleared at each reboot, written only in allowed modes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         remap_q <= '0;
      else if (load)
         remap_q <= '0;
      else if (wr_en && hit(paddr, `BCW_OFS_REMAP) && !remap_refuse)
         remap_q <= pwdata[PAGE_W-1:0];   // [RULE_12]
   end

   // software reboot request, self-clearing once the load starts
   // a write in the load cycle wins and asks again
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reboot_req_q <= 1'b0;
      else if (wr_en && hit(paddr, `BCW_OFS_CTRL) && pwdata[`BCW_CTRL_REBOOT])
         reboot_req_q <= 1'b1;
      else if (load)
         reboot_req_q <= 1'b0;
   end

   // boot selection decoder, fed from the flash word on the load strobe
   assign cfg_if.load = load;
   assign cfg_if.mode = flash_cfg_word[`BCW_BOOT_MSB:`BCW_BOOT_LSB];
   assign boot_ctl    = cfg_if.ctl;

   bcw_boot_decode u_boot_decode (
      .pclk    (pclk),
      .presetn (presetn),
      .cfg     (cfg_if.dec)
   );

   // gpio start-up mode fans out to every pin
   // one flop feeds all pins, so they never disagree
   for (genvar i = 0; i < NUM_GPIO; i++)
   begin : g_gpio
      assign gpio_quasi_mode[i] = gpio_q;   // [RULE_06]
   end

   // read mux; reserved bits read zero
   // unmapped offsets and the write-only control read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (1'b1)
         hit(paddr, `BCW_OFS_ACTIVE) : rdata_d = active_q;
         hit(paddr, `BCW_OFS_CLKSEL) : rdata_d[2:0] = clksel_q;
         hit(paddr, `BCW_OFS_REMAP)  : rdata_d[PAGE_W-1:0] = remap_q;
         hit(paddr, `BCW_OFS_STATUS) :
         begin
            rdata_d[`BCW_ST_LOADED]  = loaded_q;
            rdata_d[`BCW_ST_RSVCLK]  = rsv_clk;
            rdata_d[`BCW_ST_REMAPOK] = boot_ctl.remap_ok;
            rdata_d[`BCW_ST_MODE_LSB+1:`BCW_ST_MODE_LSB] =
               active_q[`BCW_BOOT_MSB:`BCW_BOOT_LSB];
         end
         default                     : rdata_d = 32'h0000_0000;
      endcase
   end

   // read data held in a flop, loaded in the setup cycle so it is valid
   // during the access phase
   // trade-off: the setup cycle is spare, so the flop costs no wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rdata_d;
   end

   // outputs come straight from the flops, the reserved flag through the clock code check
   assign clock_select_register_zero = clksel_q;
   assign clk_src_reserved           = rsv_clk;
   assign brownout_detect_en         = bod_en_q;
   assign brownout_reset_en          = bor_en_q;
   assign brownout_level             = bov_q;
   assign remap_page                 = remap_q;
   assign cfg_loaded                 = loaded_q;

   // load copies the clock code
   a_clk_copy: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_02]
      load |=> clock_select_register_zero
               == active_q[`BCW_CLKSRC_MSB:`BCW_CLKSRC_LSB])
      else $error("clock select not loaded from word");

   // valid codes never flagged
   a_clk_code: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_01]
      cfg_loaded && (active_q[`BCW_CLKSRC_MSB:`BCW_CLKSRC_LSB] == `BCW_CLK_XTAL
      || active_q[`BCW_CLKSRC_MSB:`BCW_CLKSRC_LSB] == `BCW_CLK_IRC) |-> !clk_src_reserved)
      else $error("valid clock code flagged reserved");

   // detect enable from the word
   a_bod_det: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_03]
      $rose(cfg_loaded) |-> brownout_detect_en == !active_q[`BCW_BOD_DIS_BIT])
      else $error("brown-out detect enable wrong");

   // reset enable from the word
   a_bod_rst: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_04]
      $rose(cfg_loaded) |-> brownout_reset_en == !active_q[`BCW_BOR_DIS_BIT])
      else $error("brown-out reset enable wrong");

   // threshold forwarded
   a_bod_level: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_05]
      $rose(cfg_loaded) |-> brownout_level == active_q[`BCW_BOV_MSB:`BCW_BOV_LSB])
      else $error("brown-out level not forwarded");

   // gpio start-up mode
   a_gpio_mode: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_06]
      $rose(cfg_loaded) |-> gpio_quasi_mode[0] == active_q[`BCW_GPIO_BIT])
      else $error("gpio start-up mode wrong");

   // single-region modes keep the remap
   a_remap_gate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
      wr_en && hit(paddr, `BCW_OFS_REMAP) && !boot_ctl.remap_ok && !load
      |=> $stable(remap_page))
      else $error("remap taken in a single-region mode");

   // word held while running
   a_word_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
      state_q == BCW_ST_RUN |=> $stable(active_q))
      else $error("applied word changed without reboot");

   // boot controls move only on a reboot
   a_boot_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_14]
      state_q == BCW_ST_RUN |=> $stable(boot_ctl))
      else $error("boot controls changed without reboot");

   // every reboot clears the remap target
   a_remap_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_12]
      load |=> remap_page == '0)
      else $error("remap target not cleared on reboot");
endmodule

// [rtl/bcw_defines.svh]
/*
 boot configuration word decoder: field positions, encodings, register
 offsets and reset values. assumes it is included once per compile unit.
*/
`ifndef BCW_DEFINES_SVH
`define BCW_DEFINES_SVH
// configuration word fields
`define BCW_CLKSRC_MSB   26
`define BCW_CLKSRC_LSB   24
`define BCW_BOD_DIS_BIT  23
`define BCW_BOV_MSB      22
`define BCW_BOV_LSB      21
`define BCW_BOR_DIS_BIT  20
`define BCW_GPIO_BIT     10
`define BCW_BOOT_MSB     7
`define BCW_BOOT_LSB     6
// clock source codes
`define BCW_CLK_XTAL     3'h0
`define BCW_CLK_IRC      3'h7
// boot selection codes
`define BCW_BOOT_APP     2'h3
`define BCW_BOOT_LDR     2'h1
`define BCW_BOOT_APP_IAP 2'h2
`define BCW_BOOT_LDR_IAP 2'h0
// loader window and remappable low page
`define BCW_LDR_BASE     32'h0010_0000
`define BCW_LDR_END      32'h0010_0FFF
`define BCW_LOW_END      32'h0000_01FF
// apb register byte offsets
`define BCW_OFS_ACTIVE   8'h00
`define BCW_OFS_CLKSEL   8'h04
`define BCW_OFS_REMAP    8'h08
`define BCW_OFS_STATUS   8'h0C
`define BCW_OFS_CTRL     8'h10
// status and control bit positions
`define BCW_ST_LOADED    0
`define BCW_ST_RSVCLK    1
`define BCW_ST_REMAPOK   2
`define BCW_ST_MODE_LSB  4
`define BCW_CTRL_REBOOT  0
// reset values
`define BCW_RST_WORD     32'hFFFF_FFFF
`define BCW_RST_CLKSEL   3'h7
// decoded boot controls per mode, msb first as bcw_boot_t packs them
`define BCW_CTL_APP      7'h28
`define BCW_CTL_LDR      7'h54
`define BCW_CTL_APP_IAP  7'h31
`define BCW_CTL_LDR_IAP  7'h73
`endif

// [rtl/bcw_pkg.sv]
/*
 boot configuration word decoder: shared types.
 assumes bcw_defines.svh holds the numeric constants.
*/
package bcw_pkg;
   // boot-time memory controls decoded from the boot selection field
   typedef struct packed {
      logic boot_from_loader;   // fetch starts in loader flash
      logic exec_app;           // application flash executable
      logic exec_loader;        // loader flash executable
      logic app_wr_block;       // writes to application flash refused
      logic ldr_wr_block;       // writes to loader flash refused
      logic ldr_low_page;       // first page fetched from loader flash
      logic remap_ok;           // low page may be remapped
   } bcw_boot_t;

   // load sequencer, one-hot
   typedef enum logic [1:0] {
      BCW_ST_LOAD = 2'b01,
      BCW_ST_RUN  = 2'b10
   } bcw_state_t;
endpackage

// [rtl/bcw_cfg_if.sv]
/*
 carrier between the sequencer and the boot selection decoder.
 assumes both ends share pclk.
*/
`timescale 1ns/100ps
interface bcw_cfg_if;
   import bcw_pkg::*;
   logic        load;   // one-cycle apply strobe
   logic [1:0]  mode;   // boot selection code being applied
   bcw_boot_t   ctl;    // registered decoded controls
   modport src (output load, output mode, input ctl);
   modport dec (input load, input mode, output ctl);
endinterface

// [rtl/bcw_boot_decode.sv]
/*
 boot selection decoder: turns the two-bit boot selection into held memory
 controls on each apply strobe. assumes the strobe comes only at reboot.
*/
`timescale 1ns/100ps
`include "bcw_defines.svh"
module bcw_boot_decode (
   input  wire logic pclk,
   input  wire logic presetn,
   bcw_cfg_if.dec    cfg
);
   import bcw_pkg::*;

   // decode of one boot selection code
   function automatic bcw_boot_t decode_boot(input logic [1:0] m);
      bcw_boot_t b;
      b = '0;
      case (m)
         `BCW_BOOT_APP     : b = `BCW_CTL_APP;     // [RULE_07] [RULE_08]
         `BCW_BOOT_LDR     : b = `BCW_CTL_LDR;     // [RULE_09] [RULE_10]
         `BCW_BOOT_APP_IAP : b = `BCW_CTL_APP_IAP; // [RULE_11]
         `BCW_BOOT_LDR_IAP : b = `BCW_CTL_LDR_IAP; // [RULE_13]
         default           : b = '0;
      endcase
      return b;
   endfunction

   // controls change only on the apply strobe; reset is the safest mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg.ctl <= `BCW_CTL_APP;
      else if (cfg.load)
         cfg.ctl <= decode_boot(cfg.mode);
   end

   a_app_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_07]
      cfg.load && cfg.mode == `BCW_BOOT_APP |=> !cfg.ctl.boot_from_loader
      && cfg.ctl.exec_app && !cfg.ctl.exec_loader)
      else $error("app-only mode decoded wrongly");
   a_app_lock: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_08]
      cfg.load && cfg.mode == `BCW_BOOT_APP |=> cfg.ctl.app_wr_block)
      else $error("application flash not write-protected");
   a_ldr_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_09]
      cfg.load && cfg.mode == `BCW_BOOT_LDR |=> cfg.ctl.boot_from_loader
      && !cfg.ctl.exec_app && cfg.ctl.exec_loader)
      else $error("loader-only mode decoded wrongly");
   a_ldr_lock: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_10]
      cfg.load && cfg.mode == `BCW_BOOT_LDR |=> cfg.ctl.ldr_wr_block
      && !cfg.ctl.app_wr_block)
      else $error("loader flash not write-protected");
   a_app_iap: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_11]
      cfg.load && cfg.mode == `BCW_BOOT_APP_IAP |=> cfg.ctl.exec_app
      && cfg.ctl.exec_loader && !cfg.ctl.boot_from_loader && cfg.ctl.remap_ok)
      else $error("app iap mode decoded wrongly");
   a_ldr_iap: assert property (@(posedge pclk) disable iff (!presetn) // [RULE_13]
      cfg.load && cfg.mode == `BCW_BOOT_LDR_IAP |=> cfg.ctl.boot_from_loader
      && cfg.ctl.ldr_low_page && cfg.ctl.exec_app)
      else $error("loader iap mode decoded wrongly");
endmodule

// [tb/tb_top.sv]
/*
 self-checking bench for the boot configuration word decoder: drives the
 apb slave, the flash word and the warm reset pulse, and checks every
 decoded output against values worked out from the word.
 assumes bcw_defines.svh is on the include path and bcw_pkg is compiled first.
*/
`timescale 1ns/100ps
`include "bcw_defines.svh"
module tb_top;
   import bcw_pkg::*;
   localparam int NG = 16;            // gpio count handed to the design
   localparam int PW = 8;             // remap page width
   localparam int MP = 100;           // below 2**PW so an out-of-range page exists
   logic          pclk;               // 10 MHz bus clock
   logic          presetn;            // power-on reset, active low
   logic          psel;               // apb select
   logic          penable;            // apb access phase
   logic          pwrite;             // apb direction
   logic [7:0]    paddr;              // apb byte address
   logic [31:0]   pwdata;             // apb write data
   logic [31:0]   prdata;             // apb read data
   logic          pready;             // apb ready
   logic          pslverr;            // apb error
   logic [31:0]   flash_cfg_word;     // word as held in flash
   logic          sys_warm_reset;     // one-cycle warm reset request
   logic [2:0]    clk_sel;            // applied clock select
   logic          clk_rsv;            // reserved clock code flag
   logic          bod_en;             // brown-out detect enable
   logic          bor_en;             // brown-out reset enable
   logic [1:0]    bov;                // brown-out threshold select
   logic [NG-1:0] gpio_q;             // gpio initial mode
   bcw_boot_t     boot_ctl;           // decoded boot controls
   logic [PW-1:0] remap_page;         // low page remap target
   logic          cfg_loaded;         // word applied at least once
   int            failures;           // mismatches seen
   int            total_checks;       // comparisons made
   int            cycles;             // timeout counter
   logic [31:0]   rd;                 // last read data
   logic          er;                 // last error response
   logic [31:0]   w0;                 // first power-on word
   logic [31:0]   w;                  // word under test
   logic [2:0]    c;                  // clock code under test
   bcw_top #(.NUM_GPIO(NG), .PAGE_W(PW), .MAX_PAGE(MP)) bcw_top_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_cfg_word(flash_cfg_word),
      .sys_warm_reset(sys_warm_reset), .clock_select_register_zero(clk_sel),
      .clk_src_reserved(clk_rsv), .brownout_detect_en(bod_en),
      .brownout_reset_en(bor_en), .brownout_level(bov), .gpio_quasi_mode(gpio_q),
      .boot_ctl(boot_ctl), .remap_page(remap_page), .cfg_loaded(cfg_loaded)
   );
   // free-running clock, 100 ns period
   initial pclk = 1'b0;
   always #50 pclk = ~pclk;
   // verdict and end of run, the only exit
   task conclude();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // a hang anywhere counts as a mismatch; the run needs well under 3000 cycles
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         conclude();
      end
   end
   // single comparison of any value, zero-extended to a word
   task check_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   // one apb transfer; held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // power-on reset with the given flash word, reset held five cycles
   task por(input logic [31:0] wd);
      @(posedge pclk);
      presetn <= 1'b0;
      flash_cfg_word <= wd;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check_val(32'(cfg_loaded), 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   // warm reboot by pulse or by the control register
   task reboot(input logic [31:0] wd, input logic by_ctrl);
      @(posedge pclk);
      flash_cfg_word <= wd;
      if (by_ctrl)
         apb(1'b1, `BCW_OFS_CTRL, 32'h0000_0001);
      else
      begin
         @(posedge pclk);
         sys_warm_reset <= 1'b1;
         @(posedge pclk);
         sys_warm_reset <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   // build a word; unused bits left erased high
   function automatic logic [31:0] mk(input logic [2:0] cc, input logic bd,
      input logic [1:0] bv, input logic br, input logic g, input logic [1:0] m);
      logic [31:0] r;
      r = 32'hFFFF_FFFF;
      r[26:24] = cc;
      r[23] = bd;
      r[22:21] = bv;
      r[20] = br;
      r[10] = g;
      r[7:6] = m;
      return r;
   endfunction
   // boot controls per mode, msb first as the struct packs them
   function automatic logic [6:0] exp_boot(input logic [1:0] m);
      case (m)
         2'h3:    return 7'h28;   // app boot, app only, app writes blocked
         2'h1:    return 7'h54;   // loader boot, loader only, loader writes blocked
         2'h2:    return 7'h31;   // app boot, both executable, remap allowed
         default: return 7'h73;   // loader boot, both, low page from loader
      endcase
   endfunction
   // all decoded outputs; pw is the word of the last power-on
   task check_all(input logic [31:0] wd, input logic [31:0] pw);
      logic rsv;
      rsv = (wd[26:24] != 3'h0) && (wd[26:24] != 3'h7);
      check_val(32'(clk_sel), 32'(wd[26:24]));
      check_val(32'(clk_rsv), 32'(rsv));
      check_val(32'(bod_en), {31'h0, ~pw[23]});
      check_val(32'(bor_en), {31'h0, ~pw[20]});
      check_val(32'(bov), 32'(pw[22:21]));
      check_val(32'(gpio_q), pw[10] ? 32'h0000_FFFF : 32'h0);
      check_val(32'(boot_ctl), 32'(exp_boot(wd[7:6])));
      check_val(32'(cfg_loaded), 32'h1);
      check_val(32'(pready), 32'h1);
      apb(1'b0, `BCW_OFS_ACTIVE, 32'h0);
      check_val(rd, wd);
      apb(1'b0, `BCW_OFS_STATUS, 32'h0);
      check_val(rd & 32'h37, {26'h0, wd[7:6], 1'b0, ~wd[6], rsv, 1'b1});
   endtask
   // main sequence
   initial
   begin
      failures = 0;
      total_checks = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sys_warm_reset = 1'b0;
      w0 = mk(3'h0, 1'b0, 2'h2, 1'b0, 1'b1, 2'h3);
      flash_cfg_word = w0;
      por(w0);
      check_all(w0, w0);
      // app-only mode refuses a remap
      apb(1'b1, `BCW_OFS_REMAP, 32'h5);
      check_val(32'(er), 32'h1);
      check_val(32'(remap_page), 32'h0);
      // unmapped address answers with an error and zero data
      apb(1'b0, 8'h20, 32'h0);
      check_val({rd[30:0], er}, 32'h1);
      apb(1'b0, `BCW_OFS_CTRL, 32'h0);
      check_val(rd, 32'h0);
      // a new flash word stays unused while running
      @(posedge pclk);
      flash_cfg_word <= mk(3'h7, 1'b1, 2'h1, 1'b1, 1'b0, 2'h0);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      check_all(w0, w0);
      // every boot mode, clock codes incl. reserved, pulse and control reboots
      for (int i = 0; i < 4; i++)
      begin
         c = (i == 1) ? 3'h3 : ((i == 2) ? 3'h0 : 3'h7);
         apb(1'b1, `BCW_OFS_CLKSEL, {29'h0, ~c});
         apb(1'b0, `BCW_OFS_CLKSEL, 32'h0);
         check_val(32'(rd[2:0]), {29'h0, ~c});
         w = mk(c, 1'b1, 2'h1, 1'b1, 1'b0, 2'(i));
         reboot(w, i == 3);
         check_all(w, w0);
         // remap only in the both-region modes, only inside the range
         apb(1'b1, `BCW_OFS_REMAP, 32'(MP));
         check_val(32'(er), 32'(w[6]));
         apb(1'b1, `BCW_OFS_REMAP, 32'(MP + 1));
         check_val(32'(er), 32'h1);
         @(negedge pclk);
         check_val(32'(remap_page), w[6] ? 32'h0 : 32'(MP));
      end
      // second power-on picks up the power-on-only fields
      w = mk(3'h7, 1'b1, 2'h1, 1'b1, 1'b0, 2'h1);
      por(w);
      check_all(w, w);
      conclude();
   end
endmodule
